//--- logic/pie_entry.v
// Interrupt entry sequencer of an 8-bit processor core.
// Assumes the core pulses insn_done at each instruction boundary, stays
// stalled while stall_q is high, and memory returns read data one cycle
// after mem_re_q.
//
// Notes on behaviour
// - A low level on the shared request line counts as a pending request.
// - A pending request is taken only at an instruction boundary.
// - On entry the program counter and status are written through the stack pointer.
// - The handler address is then read as low and high bytes from two fixed locations.
// - The fetched address is loaded into the program counter with no software help.
// - The level line interrupts only while the status mask flag is clear.
// - Accepting any interrupt sets the status mask flag.
// - The edge input holds at most one pending interrupt; falling transitions before it is serviced count as one.
// - The edge input is taken whatever the mask flag says.
`timescale 1ns/1ps
`default_nettype none
`include "pie_consts.vh"

module pie_entry #(
  parameter [15:0] LVL_VEC_ADDR  = 16'hFFF0,  // Level handler vector, low byte
  parameter [15:0] EDGE_VEC_ADDR = 16'hFFF2,  // Edge handler vector, low byte
  parameter [7:0]  STACK_PAGE    = 8'h01      // High address byte of the stack
) (
  input  wire        clk,            // System clock, 10 MHz
  input  wire        rst,            // Asynchronous reset, active high
  input  wire        lvl_req_n,      // Shared wired request line, active low
  input  wire        edge_req_n,     // Edge request line, active low
  input  wire        insn_done,      // Instruction boundary pulse from core
  input  wire [15:0] pc_in,          // Return address from core
  input  wire [7:0]  status_in,      // Status register from core
  input  wire [7:0]  sp_in,          // Stack pointer from core
  input  wire [7:0]  mem_rdata,      // Memory read data
  output reg  [15:0] mem_addr_q,     // Memory address
  output reg  [7:0]  mem_wdata_q,    // Memory write data
  output reg         mem_we_q,       // Memory write strobe
  output reg         mem_re_q,       // Memory read strobe
  output reg         stall_q,        // Core must hold while high
  output reg  [7:0]  status_q,       // Status with mask flag set
  output reg         status_load_q,  // Core loads status_q
  output reg  [7:0]  sp_q,           // Stack pointer after pushes
  output reg         sp_load_q,      // Core loads sp_q
  output reg  [15:0] pc_q,           // Handler address
  output reg         pc_load_q,      // Core loads pc_q and fetches there
  output reg         taken_q,        // Entry started
  output reg         taken_edge_q    // Entry was for the edge input
);

  // ----------------------------------------------------------------------
  // States
  // ----------------------------------------------------------------------
  localparam [6:0] S_IDLE = 7'h01;
  localparam [6:0] S_PCL  = 7'h02;
  localparam [6:0] S_PS   = 7'h04;
  localparam [6:0] S_VLO  = 7'h08;
  localparam [6:0] S_VHI  = 7'h10;
  localparam [6:0] S_CAPL = 7'h20;
  localparam [6:0] S_CAPH = 7'h40;

  reg  [6:0]  state_q, state_d;
  reg  [15:0] ret_pc_q, ret_pc_d;
  reg  [7:0]  ret_ps_q, ret_ps_d;
  reg  [7:0]  sp_wk_q, sp_wk_d;
  reg  [15:0] vec_q, vec_d;
  reg  [7:0]  vec_lo_q, vec_lo_d;
  reg  [15:0] mem_addr_d;
  reg  [7:0]  mem_wdata_d;
  reg         mem_we_d, mem_re_d, stall_d;
  reg  [7:0]  status_d;
  reg         status_load_d;
  reg  [7:0]  sp_d;
  reg         sp_load_d;
  reg  [15:0] pc_d;
  reg         pc_load_d;
  reg         taken_d, taken_edge_d;

  wire        edge_pend;
  wire        lvl_want;
  wire        boundary;
  wire        take_edge;
  wire        take_lvl;

  // ----------------------------------------------------------------------
  // Request qualification
  // ----------------------------------------------------------------------
  // Level request honoured only with the mask clear
  assign lvl_want  = ~lvl_req_n & ~status_in[`PIE_MASK_BIT];
  // Only between instructions and only while no entry is in flight
  assign boundary  = insn_done & state_q[0];
  // Edge wins a tie; it cannot be masked so it must not be starved
  assign take_edge = boundary & edge_pend;
  assign take_lvl  = boundary & ~edge_pend & lvl_want;

  pie_edge_catch u_edge (
    .clk    (clk),
    .rst    (rst),
    .req_n  (edge_req_n),
    .clr    (take_edge),
    .pend_q (edge_pend)
  );

  // ----------------------------------------------------------------------
  // Entry sequencer, next-state and next outputs
  // ----------------------------------------------------------------------
  // Strobes default to their idle values so each strobe drops one cycle after the last state that sets it (mem_we_q spans three cycles)
  always @* begin
    state_d       = state_q;
    ret_pc_d      = ret_pc_q;
    ret_ps_d      = ret_ps_q;
    sp_wk_d       = sp_wk_q;
    vec_d         = vec_q;
    vec_lo_d      = vec_lo_q;
    mem_addr_d    = mem_addr_q;
    mem_wdata_d   = mem_wdata_q;
    mem_we_d      = 1'b0;
    mem_re_d      = 1'b0;
    stall_d       = stall_q;
    status_d      = status_q;
    status_load_d = 1'b0;
    sp_d          = sp_q;
    sp_load_d     = 1'b0;
    pc_d          = pc_q;
    pc_load_d     = 1'b0;
    taken_d       = 1'b0;
    taken_edge_d  = 1'b0;
    case (state_q)
      S_IDLE: begin
        if (take_edge | take_lvl) begin
          ret_pc_d      = pc_in;
          ret_ps_d      = status_in;
          vec_d         = take_edge ? EDGE_VEC_ADDR : LVL_VEC_ADDR;
          // First push: PC high at the current stack slot
          mem_addr_d    = {STACK_PAGE, sp_in};
          mem_wdata_d   = pc_in[15:8];
          mem_we_d      = 1'b1;
          sp_wk_d       = sp_in - `PIE_SP_STEP;
          // Mask the level line so a held request is not taken twice
          status_d      = status_in | `PIE_MASK_SET;
          status_load_d = 1'b1;
          stall_d       = 1'b1;
          taken_d       = 1'b1;
          taken_edge_d  = take_edge;
          state_d       = S_PCL;
        end
      end
      S_PCL: begin
        mem_addr_d  = {STACK_PAGE, sp_wk_q};
        mem_wdata_d = ret_pc_q[7:0];
        mem_we_d    = 1'b1;
        sp_wk_d     = sp_wk_q - `PIE_SP_STEP;
        state_d     = S_PS;
      end
      S_PS: begin
        // Status pushed as it was before the mask was set
        mem_addr_d  = {STACK_PAGE, sp_wk_q};
        mem_wdata_d = ret_ps_q;
        mem_we_d    = 1'b1;
        sp_wk_d     = sp_wk_q - `PIE_SP_STEP;
        state_d     = S_VLO;
      end
      S_VLO: begin
        mem_addr_d  = vec_q;
        mem_re_d    = 1'b1;
        sp_d        = sp_wk_q;
        sp_load_d   = 1'b1;
        state_d     = S_VHI;
      end
      S_VHI: begin
        mem_addr_d  = vec_q + `PIE_VEC_STEP;
        mem_re_d    = 1'b1;
        state_d     = S_CAPL;
      end
      S_CAPL: begin
        // Low byte arrives one cycle after its strobe
        vec_lo_d    = mem_rdata;
        state_d     = S_CAPH;
      end
      S_CAPH: begin
        pc_d        = {mem_rdata, vec_lo_q};
        pc_load_d   = 1'b1;
        mem_addr_d  = {mem_rdata, vec_lo_q};
        stall_d     = 1'b0;
        state_d     = S_IDLE;
      end
      default: begin
        stall_d     = 1'b0;
        state_d     = S_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  // All outputs come straight from these flops
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q       <= S_IDLE;
      ret_pc_q      <= `PIE_ADDR_RST;
      ret_ps_q      <= `PIE_DATA_RST;
      sp_wk_q       <= `PIE_DATA_RST;
      vec_q         <= `PIE_ADDR_RST;
      vec_lo_q      <= `PIE_DATA_RST;
      mem_addr_q    <= `PIE_ADDR_RST;
      mem_wdata_q   <= `PIE_DATA_RST;
      mem_we_q      <= 1'b0;
      mem_re_q      <= 1'b0;
      stall_q       <= 1'b0;
      status_q      <= `PIE_DATA_RST;
      status_load_q <= 1'b0;
      sp_q          <= `PIE_DATA_RST;
      sp_load_q     <= 1'b0;
      pc_q          <= `PIE_ADDR_RST;
      pc_load_q     <= 1'b0;
      taken_q       <= 1'b0;
      taken_edge_q  <= 1'b0;
    end else begin
      state_q       <= state_d;
      ret_pc_q      <= ret_pc_d;
      ret_ps_q      <= ret_ps_d;
      sp_wk_q       <= sp_wk_d;
      vec_q         <= vec_d;
      vec_lo_q      <= vec_lo_d;
      mem_addr_q    <= mem_addr_d;
      mem_wdata_q   <= mem_wdata_d;
      mem_we_q      <= mem_we_d;
      mem_re_q      <= mem_re_d;
      stall_q       <= stall_d;
      status_q      <= status_d;
      status_load_q <= status_load_d;
      sp_q          <= sp_d;
      sp_load_q     <= sp_load_d;
      pc_q          <= pc_d;
      pc_load_q     <= pc_load_d;
      taken_q       <= taken_d;
      taken_edge_q  <= taken_edge_d;
    end
  end

endmodule // pie_entry
`default_nettype wire

//--- logic/pie_consts.vh
// Shared constants of the interrupt entry block: widths, field positions,
// reset values and bus timing.
// Assumes it is included by bare name from the design files only.
`ifndef PIE_CONSTS_VH
`define PIE_CONSTS_VH

// ----------------------------------------------------------------------
// Widths
// ----------------------------------------------------------------------
`define PIE_ADDR_W      16
`define PIE_DATA_W      8

// ----------------------------------------------------------------------
// Status register field positions
// ----------------------------------------------------------------------
`define PIE_MASK_BIT    2
`define PIE_MASK_SET    8'h04

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PIE_ADDR_RST    16'h0000
`define PIE_DATA_RST    8'h00
`define PIE_LINE_IDLE   1'b1

// ----------------------------------------------------------------------
// Memory timing and address steps: read data is valid this many cycles after the strobe
// ----------------------------------------------------------------------
`define PIE_RD_LAT      1
`define PIE_SP_STEP     8'h01
`define PIE_VEC_STEP    16'h0001

`endif

//--- logic/pie_edge_catch.v
// Falling-edge catcher for the edge request input.
// Assumes the request pin is synchronous to clk and idles high.
`timescale 1ns/1ps
`default_nettype none
`include "pie_consts.vh"

module pie_edge_catch (
  input  wire clk,     // System clock
  input  wire rst,     // Asynchronous reset, active high
  input  wire req_n,   // Edge request line, active low
  input  wire clr,     // Pending request accepted
  output reg  pend_q   // One falling edge waiting for service
);

  // ----------------------------------------------------------------------
  // Edge detection
  // ----------------------------------------------------------------------
  reg  prev_q;
  wire fall;
  wire pend_d;

  // A held-low line yields no new edge until it has been high again
  assign fall   = prev_q & ~req_n;
  // Set beats clear so an edge landing on the accept cycle is kept
  assign pend_d = fall | (pend_q & ~clr);

  // Line history and pending flag
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prev_q <= `PIE_LINE_IDLE;
      pend_q <= 1'b0;
    end else begin
      prev_q <= req_n;
      pend_q <= pend_d;
    end
  end

endmodule // pie_edge_catch
`default_nettype wire

//--- verif/pie_entry_sva.sv
// Port assertions for the interrupt entry sequencer.
// Assumes one clock domain and the seven-cycle entry walk.
`timescale 1ns/1ps
`default_nettype none
module pie_entry_sva (
  input wire logic        clk,            // Clock
  input wire logic        rst,            // Reset
  input wire logic        lvl_req_n,      // Level line
  input wire logic        insn_done,      // Boundary
  input wire logic [15:0] pc_in,          // Return address
  input wire logic [7:0]  status_in,      // Status
  input wire logic [7:0]  sp_in,          // Stack pointer
  input wire logic [7:0]  mem_rdata,      // Read data
  input wire logic [15:0] mem_addr_q,     // Address
  input wire logic [7:0]  mem_wdata_q,    // Write data
  input wire logic        mem_we_q,       // Write strobe
  input wire logic        mem_re_q,       // Read strobe
  input wire logic        stall_q,        // Core hold
  input wire logic [7:0]  status_q,       // Masked status
  input wire logic        status_load_q,  // Status load
  input wire logic [7:0]  sp_q,           // New stack pointer
  input wire logic        sp_load_q,      // Stack load
  input wire logic [15:0] pc_q,           // Handler address
  input wire logic        pc_load_q,      // Handler load
  input wire logic        taken_q,        // Entry start
  input wire logic        taken_edge_q    // Edge entry
);
  // Everything is sampled on the system clock; reset cancels checks
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  entry_boundary_a: assert property (taken_q |-> $past(insn_done))
    else $error("entry without boundary");
  level_gate_a: assert property (taken_q && !taken_edge_q |->
    $past(!lvl_req_n && !status_in[2]))
    else $error("level entry while masked or idle");
  mask_set_a: assert property (taken_q |-> status_load_q &&
    status_q == ($past(status_in) | 8'h04))
    else $error("mask not set on entry");
  first_push_a: assert property (taken_q |-> mem_we_q &&
    mem_addr_q == {8'h01, $past(sp_in)} && mem_wdata_q == $past(pc_in[15:8]))
    else $error("first push wrong");
  // The stack pointer wraps inside its page, so only the low byte counts down
  push_order_a: assert property (taken_q |=>
    mem_we_q && mem_addr_q == {8'h01, $past(mem_addr_q[7:0]) - 8'h01}
    ##1 mem_we_q && mem_addr_q == {8'h01, $past(mem_addr_q[7:0]) - 8'h01})
    else $error("push addresses not descending");
  sp_after_a: assert property (taken_q |-> ##3 sp_load_q &&
    sp_q == $past(sp_in, 4) - 8'h03)
    else $error("stack pointer not moved by three");
  handler_load_a: assert property (taken_q |->
    stall_q[*6] ##1 (pc_load_q && !stall_q))
    else $error("handler load timing wrong");
  vector_pair_a: assert property (pc_load_q |->
    pc_q == {$past(mem_rdata), $past(mem_rdata, 2)} && mem_addr_q == pc_q)
    else $error("handler address not from vector");
  // Vector reads come low byte first from the fixed location of the source
  vec_read_a: assert property (taken_q |-> ##3 mem_re_q && !mem_we_q &&
    mem_addr_q == ($past(taken_edge_q, 3) ? 16'hFFF2 : 16'hFFF0)
    ##1 mem_re_q && mem_addr_q == $past(mem_addr_q) + 16'h0001)
    else $error("vector reads wrong");
  no_reentry_a: assert property (taken_q |=> !taken_q[*6])
    else $error("entry restarted while busy");

  // Main scenarios seen at least once
  cover property (taken_q && taken_edge_q);
  cover property (taken_q && !taken_edge_q);
  cover property (pc_load_q ##1 taken_q);
endmodule  // pie_entry_sva
bind pie_entry pie_entry_sva CHK (.*);
`default_nettype wire

//--- verif/pie_periph.sv
// Peripheral interface devices sharing the pulled-up request line.
// Assumes strobes, enables and clears are synchronous to clk.
`timescale 1ns/1ps
`default_nettype none
module pie_periph (
  input  wire logic       clk,     // System clock
  input  wire logic       rst,     // Reset, active high
  input  wire logic [1:0] strobe,  // Keyboard strobe per source
  input  wire logic [1:0] enable,  // Interrupt enable per source
  input  wire logic [1:0] clear,   // Service clears the latch
  output wire logic       irq_n    // Shared request line
);
  logic [1:0] strobe_q, flag_q;
  // One latched condition per strobe rise, held until serviced
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      strobe_q <= 2'h0;
      flag_q   <= 2'h0;
    end else begin
      strobe_q <= strobe;
      flag_q   <= (flag_q | (strobe & ~strobe_q)) & ~clear;
    end
  end
  // Sources only pull low; the pull-up gives the idle high
  assign irq_n = ~|(flag_q & enable);
endmodule  // pie_periph
`default_nettype wire

//--- verif/tb_processor_interrupt_entry.sv
// Self-checking bench: core, memory and peripherals around the sequencer.
// Assumes the checker is bound to the design by its own file.
`timescale 1ns/1ps
`default_nettype none
module tb_processor_interrupt_entry;
  logic        clk = 0, rst = 1, edge_n = 1, done = 0;
  logic [15:0] pc = 16'h0000;
  logic [7:0]  st = 8'h00, sp = 8'h00, rdata = 8'h00;
  logic [1:0]  stb = 2'h0, en = 2'h0, clr = 2'h0;
  wire         lvl_n, we, re, stall, stl, spl, pcl, tk, tke;
  wire  [15:0] addr, pcq;
  wire  [7:0]  wdata, stq, spq;
  logic [7:0]  vec [0:3];
  logic [23:0] wq [$];
  int          bad_count = 0, check_count = 0, n;

  pie_entry DUT (.clk(clk), .rst(rst), .lvl_req_n(lvl_n), .edge_req_n(edge_n),
    .insn_done(done), .pc_in(pc), .status_in(st), .sp_in(sp), .mem_rdata(rdata),
    .mem_addr_q(addr), .mem_wdata_q(wdata), .mem_we_q(we), .mem_re_q(re),
    .stall_q(stall), .status_q(stq), .status_load_q(stl), .sp_q(spq), .sp_load_q(spl),
    .pc_q(pcq), .pc_load_q(pcl), .taken_q(tk), .taken_edge_q(tke));
  pie_periph PER (.clk(clk), .rst(rst), .strobe(stb), .enable(en), .clear(clr),
    .irq_n(lvl_n));

  always #50 clk = ~clk;
  // Memory: vectors answer one cycle late, other reads see noise
  always @(posedge clk) begin
    rdata <= #1 (re && addr[15:2] == 14'h3FFC) ? vec[addr[1:0]] : 8'($urandom);
    if (we) wq.push_back({addr, wdata});
  end

  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic ok, input string m);
    check_count++;
    if (!ok) begin
      bad_count++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic complete_run;
    if (bad_count == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // One boundary, then the whole entry against the stack model
  task automatic entry(input logic ed);
    logic [15:0] v;
    int w;
    pc = 16'($urandom);
    sp = 8'($urandom);
    foreach (vec[i]) vec[i] = 8'($urandom);
    v = ed ? 16'hFFF2 : 16'hFFF0;
    wq.delete();
    done = 1;
    cyc(1);
    done = 0;
    chk(tk === 1'b1 && tke === ed && stl === 1'b1 && stq === (st | 8'h04), "entry start");
    w = 0;
    while (pcl !== 1'b1 && w < 20) begin
      cyc(1);
      w++;
    end
    chk(w == 6 && pcq === {vec[v[1:0] + 1], vec[v[1:0]]} && addr === pcq, "handler");
    chk(wq.size() == 3 && wq[0] === {8'h01, sp, pc[15:8]}, "push 1");
    chk(wq[1] === {8'h01, sp - 8'h01, pc[7:0]}, "push 2");
    chk(wq[2] === {8'h01, sp - 8'h02, st}, "push 3");
  endtask
  // Boundaries every cycle; no entry may start
  task automatic quiet(input int k, input string m);
    n = 0;
    done = 1;
    repeat (k) begin
      cyc(1);
      n += (tk !== 1'b0);
    end
    done = 0;
    chk(n == 0, m);
  endtask

  initial begin
    n = $urandom(80);
    cyc(10);
    rst = 0;
    en = 2'h1;
    stb = 2'h1;
    cyc(1);
    stb = 2'h0;
    cyc(1);
    chk(lvl_n === 1'b0, "line not low");
    st = 8'($urandom) & 8'hFB;
    entry(1'b0);
    st = st | 8'h04;
    quiet(8, "masked level taken");
    clr = 2'h1;
    cyc(1);
    clr = 2'h0;
    cyc(1);
    chk(lvl_n === 1'b1, "line not idle");
    stb = 2'h2;
    cyc(1);
    stb = 2'h0;
    st = st & 8'hFB;
    quiet(8, "disabled source taken");
    en = 2'h3;
    cyc(1);
    entry(1'b0);
    st = 8'h04;
    edge_n = 0;
    cyc(2);
    entry(1'b1);
    quiet(8, "held edge taken again");
    edge_n = 1;
    cyc(2);
    edge_n = 0;
    cyc(2);
    st = 8'h00;
    entry(1'b1);
    entry(1'b0);
    complete_run();
  end
  // Whole run is some 80 cycles; allow over twelve times that
  initial begin
    #100000;
    bad_count++;
    complete_run();
  end
endmodule  // tb_processor_interrupt_entry
`default_nettype wire
